/* hw/ipsp_pkg.sv */
// Types shared by the peripheral port files
package ipsp_pkg;

	// Port operating modes
	typedef enum logic [1:0] {
		IPSP_SBP    = 2'b00,
		IPSP_OFF    = 2'b01,
		IPSP_MASTER = 2'b10,
		IPSP_SLAVE  = 2'b11
	} ipsp_mode_t;

endpackage

/* hw/ipsp_port.sv */
// Peripheral serial port: legacy slot port and IOM-2 terminal mode
//
// Operation
// - Legacy port mode after reset and when written into the mode field.
// - Legacy mode outputs a 192 kHz bit clock, polarity selectable.
// - Legacy mode carries three 8-bit slots per frame.
// - Legacy frame sync pulses at 8 kHz, eight bits wide, on slot one.
// - Clock and sync float until a mux link or IOM-2 mode, or disabled.
// - Timing follows S frame marks, or frame sync in slave mode; free-runs without them.
// - Idle drives sync low with clock running; power-down floats both.
// - Sample input on rising bit clock, change output on falling.
// - IOM-2 master drives clocks, open-drain data; deactivated holds clocks low.
// - IOM-2 slave takes clocks in, floats strobe, reverses data pins.
// - IOM-2 frame is three 32-bit subframes, twelve bytes at 8 kHz.
// - C/I field is four bits in subframe 0, six in subframe 1.
// - Channels go MSB first, D channel LSB first, both directions.
// - B1, B2 map to slots one and two; slot three to chosen IC.
// - Flag C/I change once a new value holds two frames.
// - With TIC on, C/I0 transmit needs the bus request flag.
// - Master: D with S side, copy S D to IOM-2, arbitrate if TIC.
// - Slave: D only with IOM-2, none through line interface.
// - One Monitor channel served at a time, chosen by a control bit.
// - TIC bits in last byte: 1,1,BAC,TBA2..0,1,1 up; E,E,S/G,A/B down.
// - BAC low when taken; open-drain TBA, default 111 lowest priority.
// - S/G 0 lets D go, 1 stops it; echo and A/B ignored.
`timescale 1ns/100ps
`include "ipsp_regs.svh"
module ipsp_port (
	input  wire logic                 core_clk,
	input  wire logic                 arst_n,
	input  wire logic                 linkClk,
	input  wire ipsp_pkg::ipsp_mode_t portModeIn,
	input  wire logic                 portModeWrite,
	input  wire logic                 muxConnected,
	input  wire logic                 idleMode,
	input  wire logic                 powerDown,
	input  wire logic                 iomActivated,
	input  wire logic                 busReversal,
	input  wire logic                 ticEnable,
	input  wire logic [2:0]           ticAddr,
	input  wire logic                 bitClockInvert,
	input  wire logic                 icSelect,
	input  wire logic                 monSelect,
	input  wire logic                 busRequest,
	input  wire logic [3:0]           ciTx0,
	input  wire logic [5:0]           ciTx1,
	output ipsp_pkg::ipsp_mode_t      portMode,
	output logic      [3:0]           ciRx0,
	output logic      [5:0]           ciRx1,
	output logic                      ciChangeEvent,
	output logic                      busGranted,
	input  wire logic                 sFrameMark,
	input  wire logic [7:0]           firstSlotTx,
	input  wire logic [7:0]           secondSlotTx,
	input  wire logic [7:0]           thirdSlotTx,
	input  wire logic [7:0]           monTx,
	output logic      [7:0]           firstSlotRx,
	output logic      [7:0]           secondSlotRx,
	output logic      [7:0]           thirdSlotRx,
	output logic      [7:0]           monRx,
	input  wire logic [1:0]           linkDTx,
	output logic      [1:0]           linkDRx,
	output logic                      linkDGranted,
	input  wire logic [1:0]           sDRx,
	output logic      [1:0]           sDTx,
	output logic                      portBitClockOut,
	output logic                      portBitClockOe,
	output logic                      portFrameSyncOut,
	output logic                      portFrameSyncOe,
	input  wire logic                 portFrameSyncIn,
	output logic                      bitClockOrSlotStrobeOut,
	output logic                      bitClockOrSlotStrobeOe,
	input  wire logic                 portSerialInIn,
	output logic                      portSerialInOut,
	output logic                      portSerialInOe,
	output logic                      portSerialOutOut,
	output logic                      portSerialOutOe,
	input  wire logic                 portSerialOutIn
);

	// ------------------------------------------------------------
	// Core domain: reset release, mode field, configuration
	// ------------------------------------------------------------
	logic [1:0]               coreRstPipe;
	logic                     coreRst_n;
	ipsp_pkg::ipsp_mode_t     modeReg;
	logic                     armed;
	logic [`IPSP_CFG_W-1:0]   cfgCore;
	logic [1:0]               backSync;
	logic                     togPrev;

	// Reset is released through two flops
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			coreRstPipe <= 2'h0;
		else
			coreRstPipe <= {coreRstPipe[0], 1'b1};
	end
	assign coreRst_n = coreRstPipe[1];

	// Mode field; armed latches once outputs may leave high-Z
	always_ff @(posedge core_clk or negedge coreRst_n) begin
		if (!coreRst_n) begin
			modeReg <= ipsp_pkg::IPSP_SBP;
			armed   <= 1'b0;
		end else begin
			if (portModeWrite)
				modeReg <= portModeIn;
			if (muxConnected || modeReg[1])
				armed <= 1'b1;
		end
	end
	assign portMode = modeReg;

	a_reset_mode: assert property (
		@(posedge core_clk) disable iff (!coreRst_n)
		$rose(coreRst_n) |-> modeReg == ipsp_pkg::IPSP_SBP
	) else $error("mode not legacy after reset");

	// Quasi-static bundle; software changes it only between frames
	assign cfgCore = {modeReg, armed, idleMode, powerDown, iomActivated,
		busReversal, ticEnable, ticAddr, bitClockInvert, icSelect,
		monSelect, busRequest, ciTx0, ciTx1};

	// ------------------------------------------------------------
	// Link domain: reset, crossings, unpacked controls
	// ------------------------------------------------------------
	logic [1:0]               linkRstPipe;
	logic                     linkRst_n;
	logic [`IPSP_CFG_W-1:0]   cfgLink;
	logic [`IPSP_CFG_W-1:0]   cfgPrev;
	logic [`IPSP_CFG_W-1:0]   cfgHeld;
	logic [2:0]               pinSync;
	logic [1:0]               lMode;
	logic                     lArmed, lIdle, lPd, lAct, lRev, ticEn;
	logic                     lInv, lIcSel, lMonSel, lReq;
	logic [2:0]               lAddr;
	logic [3:0]               lCi0;
	logic [5:0]               lCi1;

	always_ff @(posedge linkClk or negedge arst_n) begin
		if (!arst_n)
			linkRstPipe <= 2'h0;
		else
			linkRstPipe <= {linkRstPipe[0], 1'b1};
	end
	assign linkRst_n = linkRstPipe[1];

	ipsp_sync2 #(.W(`IPSP_CFG_W)) u_cfgSync (
		.clk   (linkClk),
		.rst_n (linkRst_n),
		.d     (cfgCore),
		.q     (cfgLink)
	);

	// Pin inputs: frame sync, serial in, serial out readback
	ipsp_sync2 #(.W(3)) u_pinSync (
		.clk   (linkClk),
		.rst_n (linkRst_n),
		.d     ({portFrameSyncIn, portSerialInIn, portSerialOutIn}),
		.q     (pinSync)
	);

	// Bits of one word may land a cycle apart; take it once it repeats
	always_ff @(posedge linkClk or negedge linkRst_n) begin
		if (!linkRst_n) begin
			cfgPrev <= '0;
			cfgHeld <= '0;
		end else begin
			cfgPrev <= cfgLink;
			if (cfgLink == cfgPrev)
				cfgHeld <= cfgLink;
		end
	end

	assign {lMode, lArmed, lIdle, lPd, lAct, lRev, ticEn, lAddr, lInv,
		lIcSel, lMonSel, lReq, lCi0, lCi1} = cfgHeld;

	// Mode decode
	wire isSbp    = lMode == ipsp_pkg::IPSP_SBP;
	wire isMaster = lMode == ipsp_pkg::IPSP_MASTER;
	wire isSlave  = lMode == ipsp_pkg::IPSP_SLAVE;
	wire isIom    = isMaster || isSlave;
	wire sbpOn    = isSbp && lArmed && !lPd;

	// ------------------------------------------------------------
	// Bit timing: linkClk runs at twice the bit rate
	// ------------------------------------------------------------
	logic       phase;
	logic [6:0] bitCnt;
	logic       fsPrev;
	logic       txBit;

	// 24 bits at 192 kHz or 96 bits at 768 kHz per 8 kHz frame
	wire [6:0] frameLast = isIom ? `IPSP_IOM_LAST : `IPSP_SBP_LAST;
	wire fsRise  = pinSync[2] && !fsPrev;
	wire realign = isSlave ? fsRise : sFrameMark;
	// Leaving IOM-2 past bit 23 must not run the legacy frame to 127
	wire [6:0] nxtBit = (bitCnt >= frameLast) ? 7'h00 : bitCnt + 7'h01;
	wire [6:0] rxIdx  = (bitCnt == 7'h00) ? frameLast : bitCnt - 7'h01;
	wire sub0 = bitCnt <= `IPSP_SUB0_LAST;

	// Phase 0 is the high half; counter and data move on the fall
	always_ff @(posedge linkClk or negedge linkRst_n) begin
		if (!linkRst_n) begin
			phase  <= 1'b0;
			bitCnt <= 7'h00;
			fsPrev <= 1'b0;
		end else begin
			fsPrev <= pinSync[2];
			if (realign) begin
				phase  <= 1'b0;
				bitCnt <= frameLast;
			end else begin
				phase <= !phase;
				if (!phase)
					bitCnt <= nxtBit;
			end
		end
	end

	a_frame_wrap: assert property (
		@(posedge linkClk) disable iff (!linkRst_n)
		bitCnt == frameLast && !phase && !realign
		|=> bitCnt == 7'h00 ##2
			(bitCnt == 7'h01 || $past(realign) || $past(realign, 2))
	) else $error("bit counter did not wrap at frame end");

	// ------------------------------------------------------------
	// Transmit byte map
	// ------------------------------------------------------------
	logic       ticOwn;
	logic       sgStop;
	logic [1:0] dIom;

	wire [3:0] txByteIdx = nxtBit[6:3];
	wire dGo      = ticOwn && !sgStop;
	wire dPermit  = !ticEn || dGo;
	wire [1:0] dToIom = isMaster ? sDRx :
		(dPermit ? linkDTx : `IPSP_D_IDLE);
	// C/I0 goes out only while the bus is ours under TIC
	wire [3:0] ci0Out = (ticEn && !(ticOwn && lReq)) ?
		`IPSP_CI0_IDLE : lCi0;
	// D bit 0 first, then D bit 1, four C/I bits, MR and MX idle
	wire [7:0] ctl0Byte = {dToIom[0], dToIom[1], ci0Out, 2'h3};
	wire [7:0] ctl1Byte = {lCi1, 2'h3};
	wire [7:0] mon0Byte = lMonSel ? `IPSP_IDLE_BYTE : monTx;
	wire [7:0] mon1Byte = lMonSel ? monTx : `IPSP_IDLE_BYTE;
	wire [7:0] ic1Byte  = lIcSel ? `IPSP_IDLE_BYTE : thirdSlotTx;
	wire [7:0] ic2Byte  = lIcSel ? thirdSlotTx : `IPSP_IDLE_BYTE;
	wire arbActive = ticEn && lReq && !ticOwn;
	wire bacOut = !(ticOwn && lReq);
	wire [2:0] tbaOut = arbActive ? lAddr : 3'h7;
	wire [7:0] ticByte = {2'h3, bacOut, tbaOut, 2'h3};

	wire [7:0] txByte =
		(txByteIdx == `IPSP_BY_FIRST)  ? firstSlotTx :
		(txByteIdx == `IPSP_BY_SECOND && isSbp) ? secondSlotTx :
		!isIom ? thirdSlotTx :
		(txByteIdx == `IPSP_BY_SECOND) ? secondSlotTx :
		(txByteIdx == `IPSP_BY_MON0)   ? mon0Byte :
		(txByteIdx == `IPSP_BY_CTL0)   ? ctl0Byte :
		(txByteIdx == `IPSP_BY_IC1)    ? ic1Byte :
		(txByteIdx == `IPSP_BY_IC2)    ? ic2Byte :
		(txByteIdx == `IPSP_BY_MON1)   ? mon1Byte :
		(txByteIdx == `IPSP_BY_CTL1)   ? ctl1Byte :
		(txByteIdx == `IPSP_BY_TIC)    ? ticByte :
		`IPSP_IDLE_BYTE;

	// New bit leaves on the falling bit clock, MSB first
	always_ff @(posedge linkClk or negedge linkRst_n) begin
		if (!linkRst_n)
			txBit <= 1'b1;
		else if (!phase && !realign)
			txBit <= txByte[~nxtBit[2:0]];
	end

	a_edge_tx: assert property (
		@(posedge linkClk) disable iff (!linkRst_n)
		phase || realign |=> $stable(txBit)
	) else $error("serial output moved off the falling edge");

	a_tic_gate: assert property (
		@(posedge linkClk) disable iff (!linkRst_n)
		isIom && ticEn && !ticOwn && txByteIdx == `IPSP_BY_CTL0
		|-> txByte[5:2] == `IPSP_CI0_IDLE
	) else $error("C/I0 sent without bus access");

	// ------------------------------------------------------------
	// Pin directions and drive
	// ------------------------------------------------------------
	// Slave with reversal swaps data pins back outside subframe 0
	wire txViaIn = isSlave && (!lRev || sub0);
	wire rxPin = txViaIn ? pinSync[0] : pinSync[1];
	wire upPin = txViaIn ? pinSync[1] : pinSync[0];
	wire clkDrive = sbpOn || (isMaster && !lPd);
	wire inFs = bitCnt <= `IPSP_FS_LAST;
	wire inSlot2 = bitCnt >= `IPSP_SLOT2_FIRST &&
		bitCnt <= `IPSP_SLOT2_LAST;

	// Deactivated master holds clocks low; idle forces sync low
	assign portBitClockOe  = clkDrive;
	assign portBitClockOut = (isMaster && !lAct) ? 1'b0 :
		(!phase ^ (isSbp && lInv));
	assign portFrameSyncOe  = clkDrive;
	assign portFrameSyncOut = clkDrive && !lIdle &&
		(isSbp || lAct) && inFs;
	assign bitClockOrSlotStrobeOe  = clkDrive;
	assign bitClockOrSlotStrobeOut = isSbp ? inSlot2 :
		(lAct && !phase);
	// Open drain in IOM-2: drive only the zeros
	assign portSerialOutOe = sbpOn ||
		(isMaster && lAct && !lPd && !txBit) ||
		(isSlave && lAct && !lPd && !txViaIn && !txBit);
	assign portSerialOutOut = sbpOn ? txBit : 1'b0;
	assign portSerialInOe  = isSlave && lAct && !lPd && txViaIn &&
		!txBit;
	assign portSerialInOut = 1'b0;

	a_pd_float: assert property (
		@(posedge linkClk) disable iff (!linkRst_n)
		lPd |-> !portBitClockOe && !portFrameSyncOe && !portSerialOutOe
	) else $error("power-down left a clock driven");

	a_idle_fs: assert property (
		@(posedge linkClk) disable iff (!linkRst_n)
		lIdle && sbpOn |-> !portFrameSyncOut && portBitClockOe
	) else $error("idle did not hold frame sync low");

	a_fs_width: assert property (
		@(posedge linkClk) disable iff (!linkRst_n)
		$fell(portFrameSyncOut) && sbpOn && !lIdle && !$past(realign)
		|-> bitCnt == `IPSP_SLOT2_FIRST
	) else $error("frame sync not eight bits wide");

	a_slave_pins: assert property (
		@(posedge linkClk) disable iff (!linkRst_n)
		isSlave |-> !portBitClockOe && !portFrameSyncOe &&
			!bitClockOrSlotStrobeOe
	) else $error("slave drove a timing pin");

	a_master_deact: assert property (
		@(posedge linkClk) disable iff (!linkRst_n)
		isMaster && !lAct && !lPd |-> portBitClockOe &&
			!portBitClockOut && !portFrameSyncOut && !portSerialOutOe
	) else $error("deactivated master not quiet");

	// ------------------------------------------------------------
	// Receive: sampled on the rising bit clock
	// ------------------------------------------------------------
	logic [6:0] rxShift, upShift;
	logic [3:0] ci0Now;
	logic [5:0] ci1Now;

	wire sample = phase && !realign;
	wire [7:0] rxByte = {rxShift, rxPin};
	wire [7:0] upByte = {upShift, upPin};
	wire byteDone = sample && rxIdx[2:0] == 3'h7;
	wire [3:0] rxByteIdx = rxIdx[6:3];
	wire frameDone = sample && rxIdx == frameLast;
	wire [3:0] thirdIdx = !isIom ? 4'h2 :
		(lIcSel ? `IPSP_BY_IC2 : `IPSP_BY_IC1);
	wire [3:0] monIdx = lMonSel ? `IPSP_BY_MON1 : `IPSP_BY_MON0;

	always_ff @(posedge linkClk or negedge linkRst_n) begin
		if (!linkRst_n) begin
			rxShift <= 7'h7F;
			upShift <= 7'h7F;
		end else if (sample) begin
			rxShift <= rxByte[6:0];
			upShift <= upByte[6:0];
		end
	end

	// Byte stores; IOM-only fields are ignored in legacy mode
	always_ff @(posedge linkClk or negedge linkRst_n) begin
		if (!linkRst_n) begin
			firstSlotRx  <= `IPSP_IDLE_BYTE;
			secondSlotRx <= `IPSP_IDLE_BYTE;
			thirdSlotRx  <= `IPSP_IDLE_BYTE;
			monRx        <= `IPSP_IDLE_BYTE;
			dIom         <= `IPSP_D_IDLE;
			ci0Now       <= `IPSP_CI0_IDLE;
			ci1Now       <= 6'h3F;
			sgStop       <= 1'b1;
		end else if (byteDone) begin
			if (rxByteIdx == `IPSP_BY_FIRST)
				firstSlotRx <= rxByte;
			if (rxByteIdx == `IPSP_BY_SECOND)
				secondSlotRx <= rxByte;
			if (rxByteIdx == thirdIdx)
				thirdSlotRx <= rxByte;
			if (isIom && rxByteIdx == monIdx)
				monRx <= rxByte;
			if (isIom && rxByteIdx == `IPSP_BY_CTL0) begin
				dIom   <= {rxByte[6], rxByte[7]};
				ci0Now <= rxByte[5:2];
			end
			if (isIom && rxByteIdx == `IPSP_BY_CTL1)
				ci1Now <= rxByte[7:2];
			// Only S/G counts; echo and A/B are dropped
			if (isIom && rxByteIdx == `IPSP_BY_TIC)
				sgStop <= rxByte[5];
		end
	end

	// ------------------------------------------------------------
	// TIC arbitration, judged on the readback of our own line
	// ------------------------------------------------------------
	wire bacFree = upByte[5];
	wire tbaWon  = upByte[4:2] == lAddr;
	wire ticByteEnd = byteDone && rxByteIdx == `IPSP_BY_TIC;

	always_ff @(posedge linkClk or negedge linkRst_n) begin
		if (!linkRst_n)
			ticOwn <= 1'b0;
		else if (!ticEn || !lReq || !isIom)
			ticOwn <= 1'b0;
		else if (ticByteEnd && arbActive && bacFree && tbaWon)
			ticOwn <= 1'b1;
	end

	a_sg_stop: assert property (
		@(posedge linkClk) disable iff (!linkRst_n)
		ticEn && sgStop |-> !linkDGranted
	) else $error("D granted while stop is signalled");

	// ------------------------------------------------------------
	// D channel routing, once per frame
	// ------------------------------------------------------------
	assign linkDGranted = isSlave ? dPermit : (!ticEn || dGo);

	always_ff @(posedge linkClk or negedge linkRst_n) begin
		if (!linkRst_n) begin
			sDTx    <= `IPSP_D_IDLE;
			linkDRx <= `IPSP_D_IDLE;
		end else if (frameDone) begin
			if (isSlave) begin
				sDTx    <= `IPSP_D_IDLE;
				linkDRx <= dIom;
			end else begin
				sDTx    <= (!isMaster || !ticEn || dGo) ?
					linkDTx : dIom;
				linkDRx <= sDRx;
			end
		end
	end

	// ------------------------------------------------------------
	// C/I change detector, one per channel
	// ------------------------------------------------------------
	logic [5:0] ciNow [2];
	logic [5:0] ciAcc [2];
	logic [1:0] ciHit;
	logic       ciToggle;

	// Padded with ones so the idle code matches the reset history
	assign ciNow[0] = {2'h3, ci0Now};
	assign ciNow[1] = ci1Now;

	for (genvar g = 0; g < 2; g++) begin : g_ci
		logic [5:0] last, acc;
		// A new value must repeat in the next frame to count
		assign ciHit[g] = frameDone && isIom &&
			ciNow[g] != acc && ciNow[g] == last;
		assign ciAcc[g] = acc;
		always_ff @(posedge linkClk or negedge linkRst_n) begin
			if (!linkRst_n) begin
				last <= 6'h3F;
				acc  <= 6'h3F;
			end else if (frameDone) begin
				last <= ciNow[g];
				if (ciHit[g])
					acc <= ciNow[g];
			end
		end
	end

	always_ff @(posedge linkClk or negedge linkRst_n) begin
		if (!linkRst_n)
			ciToggle <= 1'b0;
		else if (|ciHit)
			ciToggle <= !ciToggle;
	end

	// ------------------------------------------------------------
	// Back to the core: toggle event, grant level
	// ------------------------------------------------------------
	ipsp_sync2 #(.W(2)) u_backSync (
		.clk   (core_clk),
		.rst_n (coreRst_n),
		.d     ({ciToggle, ticOwn}),
		.q     (backSync)
	);
	assign busGranted = backSync[0];

	// Accepted words are still when the toggle lands
	always_ff @(posedge core_clk or negedge coreRst_n) begin
		if (!coreRst_n) begin
			togPrev       <= 1'b0;
			ciChangeEvent <= 1'b0;
			ciRx0         <= `IPSP_CI0_IDLE;
			ciRx1         <= 6'h3F;
		end else begin
			togPrev       <= backSync[1];
			ciChangeEvent <= backSync[1] ^ togPrev;
			if (backSync[1] ^ togPrev) begin
				ciRx0 <= ciAcc[0][3:0];
				ciRx1 <= ciAcc[1];
			end
		end
	end

endmodule

/* hw/ipsp_regs.svh */
// Frame layout, bit positions, reset values and rates of the port
`ifndef IPSP_REGS_SVH
`define IPSP_REGS_SVH

// ----------------------------------------------------------------
// Rates in kHz and derived last bit index of each frame
// ----------------------------------------------------------------
`define IPSP_SBP_KHZ      192
`define IPSP_IOM_KHZ      768
`define IPSP_FRM_KHZ      8
`define IPSP_SBP_LAST     7'(`IPSP_SBP_KHZ / `IPSP_FRM_KHZ - 1)
`define IPSP_IOM_LAST     7'(`IPSP_IOM_KHZ / `IPSP_FRM_KHZ - 1)

// ----------------------------------------------------------------
// Bit positions within the frame
// ----------------------------------------------------------------
`define IPSP_FS_LAST      7'h07
`define IPSP_SLOT2_FIRST  7'h08
`define IPSP_SLOT2_LAST   7'h0F
`define IPSP_SUB0_LAST    7'h1F

// ----------------------------------------------------------------
// Byte indices within the twelve byte frame
// ----------------------------------------------------------------
`define IPSP_BY_FIRST     4'h0
`define IPSP_BY_SECOND    4'h1
`define IPSP_BY_MON0      4'h2
`define IPSP_BY_CTL0      4'h3
`define IPSP_BY_IC1       4'h4
`define IPSP_BY_IC2       4'h5
`define IPSP_BY_MON1      4'h6
`define IPSP_BY_CTL1      4'h7
`define IPSP_BY_TIC       4'hB

// ----------------------------------------------------------------
// Reset and idle values, bundle width
// ----------------------------------------------------------------
`define IPSP_IDLE_BYTE    8'hFF
`define IPSP_CI0_IDLE     4'hF
`define IPSP_D_IDLE       2'h3
`define IPSP_CFG_W        25

`endif

/* hw/ipsp_sync2.sv */
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module ipsp_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta;

	// Width must be served by the flops
	if (W < 1) begin : g_bad_w
		$error("ipsp_sync2: W must be at least 1");
	end

	// First stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule

/* tb/ipsp_peer_model.sv */
// Legacy slot peripheral driving the port's serial input
`timescale 1ns/100ps
module ipsp_peer_model #(
	parameter logic [23:0] FRAME = 24'hA5_3C96
) (
	input  wire logic bitClock,
	input  wire logic frameSync,
	output logic      serialIn
);
	logic [4:0] idx;
	logic       fsPrev;
	initial begin
		idx = 5'h00;
		fsPrev = 1'b0;
		serialIn = 1'b1;
	end
	// Change on falling clock; settle delay keeps clear of the sync edge
	always @(negedge bitClock) begin
		#1;
		if (frameSync && !fsPrev) idx = 5'h17;
		else if (idx != 5'h00) idx = idx - 5'h01;
		fsPrev = frameSync;
		serialIn = FRAME[idx];
	end
endmodule

/* tb/tb_ipsp_port.sv */
// Self-checking bench for the peripheral serial port
`timescale 1ns/100ps
module tb_ipsp_port;
	logic core_clk = 0, linkClk = 0, arst_n = 0, peerIn, portSerialInIn;
	ipsp_pkg::ipsp_mode_t portModeIn = ipsp_pkg::IPSP_SBP, portMode;
	logic portModeWrite = 0, muxConnected = 0, idleMode = 0, powerDown = 0;
	logic iomActivated = 0, busReversal = 0, ticEnable = 0, sFrameMark = 0;
	logic bitClockInvert = 0, icSelect = 0, monSelect = 0, busRequest = 0;
	logic portFrameSyncIn = 0, portSerialOutIn, loopBack = 0;
	logic [2:0] ticAddr = 3'h7;
	logic [3:0] ciTx0 = 4'hF, ciRx0;
	logic [5:0] ciTx1 = 6'h3F, ciRx1;
	logic [7:0] firstSlotTx = 8'hC3, secondSlotTx = 8'h5A;
	logic [7:0] thirdSlotTx = 8'h81, monTx = 8'hFF, monRx;
	logic [7:0] firstSlotRx, secondSlotRx, thirdSlotRx;
	logic [1:0] linkDTx = 2'h3, sDRx = 2'h3, linkDRx, sDTx;
	logic ciChangeEvent, busGranted, linkDGranted, portBitClockOut;
	logic portBitClockOe, portFrameSyncOut, portFrameSyncOe;
	logic bitClockOrSlotStrobeOut, bitClockOrSlotStrobeOe;
	logic portSerialInOut, portSerialInOe, portSerialOutOut, portSerialOutOe;
	int err_total = 0, samples_checked = 0;
	// Clocks, link offset so edges never meet
	always #10 core_clk = ~core_clk;
	initial begin
		#3;
		forever #24 linkClk = ~linkClk;
	end
	// Pulled-up open-drain line; loopback feeds it to serial in
	assign portSerialOutIn = portSerialOutOe ? portSerialOutOut : 1'b1;
	assign portSerialInIn = portSerialInOe ? portSerialInOut :
		(loopBack ? portSerialOutIn : peerIn);
	ipsp_port ipsp_port_i (.core_clk, .arst_n, .linkClk, .portModeIn,
		.portModeWrite, .muxConnected, .idleMode, .powerDown, .iomActivated,
		.busReversal, .ticEnable, .ticAddr, .bitClockInvert, .icSelect,
		.monSelect, .busRequest, .ciTx0, .ciTx1, .portMode, .ciRx0, .ciRx1,
		.ciChangeEvent, .busGranted, .sFrameMark, .firstSlotTx, .secondSlotTx,
		.thirdSlotTx, .monTx, .firstSlotRx, .secondSlotRx, .thirdSlotRx,
		.monRx, .linkDTx, .linkDRx, .linkDGranted, .sDRx, .sDTx,
		.portBitClockOut, .portBitClockOe, .portFrameSyncOut, .portFrameSyncOe,
		.portFrameSyncIn, .bitClockOrSlotStrobeOut, .bitClockOrSlotStrobeOe,
		.portSerialInIn, .portSerialInOut, .portSerialInOe, .portSerialOutOut,
		.portSerialOutOe, .portSerialOutIn);
	ipsp_peer_model ipsp_peer_model_i (.bitClock(portBitClockOut &
		portBitClockOe), .frameSync(portFrameSyncOut), .serialIn(peerIn));
	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic cmp(string nm, logic [7:0] exp, logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask
	// Next rising bit clock, bounded
	task automatic nextRise(output logic fs, output logic sd);
		int n;
		n = 0;
		while (portBitClockOut !== 1'b0 && n < 40) begin
			@(posedge core_clk);
			n++;
		end
		while (portBitClockOut !== 1'b1 && n < 40) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 40) begin
			cmp("bit clock timeout", 8'h00, 8'h01);
			summarize();
		end
		fs = portFrameSyncOut;
		sd = portSerialOutOut;
	endtask
	task automatic setMode(ipsp_pkg::ipsp_mode_t m);
		portModeIn <= m;
		portModeWrite <= 1'b1;
		@(posedge core_clk);
		portModeWrite <= 1'b0;
		repeat (20) @(posedge core_clk);
	endtask
	task automatic t_reset;
		cmp("reset mode", 8'h00, 8'(portMode));
		cmp("reset oe", 8'h00, {6'h00, portBitClockOe, portFrameSyncOe});
		cmp("reset C/I0", 8'h0F, {4'h0, ciRx0});
		$display("test reset done");
	endtask
	task automatic t_frame;
		logic fs, sd, pf;
		logic [7:0] b;
		int hi;
		muxConnected <= 1'b1;
		repeat (20) @(posedge core_clk);
		cmp("clock oe", 8'h01, {7'h00, portBitClockOe});
		fs = 1'b1;
		pf = 1'b1;
		for (int i = 0; i < 60 && !(fs && !pf); i++) begin
			pf = fs;
			nextRise(fs, sd);
		end
		hi = 0;
		for (int i = 0; i < 24; i++) begin
			if (i > 0) nextRise(fs, sd);
			hi += fs;
			if (i < 8) b = {b[6:0], sd};
		end
		pf = fs;
		nextRise(fs, sd);
		cmp("sync width", 8'h08, 8'(hi));
		cmp("frame length", 8'h01, {7'h00, fs & ~pf});
		cmp("first slot out", firstSlotTx, b);
		repeat (10) nextRise(fs, sd);
		cmp("first slot in", 8'hA5, firstSlotRx);
		cmp("second slot in", 8'h3C, secondSlotRx);
		cmp("third slot in", 8'h96, thirdSlotRx);
		$display("test frame done");
	endtask
	task automatic t_idle;
		int tg;
		logic pc;
		idleMode <= 1'b1;
		repeat (20) @(posedge core_clk);
		tg = 0;
		pc = portBitClockOut;
		repeat (60) begin
			@(posedge core_clk);
			if (portFrameSyncOut !== 1'b0 || portFrameSyncOe !== 1'b1) tg -= 99;
			if (portBitClockOut !== pc) tg++;
			pc = portBitClockOut;
		end
		cmp("idle sync low", 8'h01, {7'h00, tg > 10});
		powerDown <= 1'b1;
		repeat (20) @(posedge core_clk);
		cmp("down oe", 8'h00, {6'h00, portBitClockOe, portFrameSyncOe});
		idleMode <= 1'b0;
		powerDown <= 1'b0;
		repeat (20) @(posedge core_clk);
		$display("test idle done");
	endtask
	task automatic t_mode;
		setMode(ipsp_pkg::IPSP_OFF);
		cmp("mode off", 8'h01, 8'(portMode));
		cmp("off oe", 8'h00, {6'h00, portBitClockOe, portFrameSyncOe});
		setMode(ipsp_pkg::IPSP_SBP);
		cmp("mode legacy", 8'h00, 8'(portMode));
		cmp("on oe", 8'h03, {6'h00, portBitClockOe, portFrameSyncOe});
		$display("test mode done");
	endtask
	// IOM-2 master, frame looped back through the open-drain line
	task automatic t_master;
		int n;
		ciTx0 <= 4'hA;
		ciTx1 <= 6'h15;
		sDRx <= 2'h1;
		linkDTx <= 2'h2;
		loopBack <= 1'b1;
		iomActivated <= 1'b1;
		setMode(ipsp_pkg::IPSP_MASTER);
		cmp("master oe", 8'h03, {6'h00, portBitClockOe, portFrameSyncOe});
		n = 0;
		while (ciChangeEvent !== 1'b1 && n < 2000) begin
			@(posedge core_clk);
			n++;
		end
		cmp("C/I event", 8'h01, {7'h00, ciChangeEvent});
		cmp("C/I0 in", 8'h0A, {4'h0, ciRx0});
		cmp("C/I1 in", 8'h15, {2'h0, ciRx1});
		cmp("B1 loop", firstSlotTx, firstSlotRx);
		cmp("IC loop", thirdSlotTx, thirdSlotRx);
		cmp("D route", 8'h16, {3'h0, linkDGranted, linkDRx, sDTx});
		ticAddr <= 3'h2;
		ticEnable <= 1'b1;
		busRequest <= 1'b1;
		n = 0;
		while (busGranted !== 1'b1 && n < 3000) begin
			@(posedge core_clk);
			n++;
		end
		repeat (700) @(posedge core_clk);
		cmp("bus taken", 8'h01, {7'h00, busGranted});
		cmp("D go", 8'h01, {7'h00, linkDGranted});
		$display("test master done");
	endtask
	// Second reset in mid-run, out of master mode
	task automatic t_rerun;
		arst_n <= 1'b0;
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_reset();
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_reset();
		t_frame();
		t_idle();
		t_mode();
		t_master();
		t_rerun();
		summarize();
	end
endmodule
